// ==== design/integ_sensor.sv ====
// Sensor end: register file and integration period controller
`timescale 1ns/1ps
`default_nettype none
module integ_sensor #(
	parameter longint CYC12 = integ_pkg::C12,
	parameter longint CYC100 = integ_pkg::C100,
	parameter longint CYC400 = integ_pkg::C400
) (
	input wire logic sys_clk,
	input wire logic rst,
	integ_if.sensor link,
	output logic integrating,
	output logic cycleDone,
	output logic [7:0] controlValue,
	output logic [7:0] timingValue,
	output logic [7:0] gainValue,
	output logic [3:0] pulseCount
);
	// ==========================================================
	// Register writes: command byte then data byte
	logic [7:0] control_reg, control_next;
	logic [7:0] timing_reg, timing_next;
	logic [7:0] gain_reg, gain_next;
	logic [4:0] addr_reg, addr_next;
	logic haveAddr_reg, haveAddr_next;
	logic sync1_reg, sync2_reg, syncOld_reg;

	// Command with MSB set latches address, next byte is data
	always_comb begin
		control_next = control_reg;
		timing_next = timing_reg;
		gain_next = gain_reg;
		addr_next = addr_reg;
		haveAddr_next = haveAddr_reg;
		if (link.cmdValid) begin
			if (link.cmdByte[integ_pkg::CMD_SEL_BIT]) begin
				addr_next = link.cmdByte[4:0];
				haveAddr_next = 1'b1;
			end else if (haveAddr_reg) begin
				unique case (addr_reg)
					integ_pkg::CONTROL_OFS: control_next = link.dataByte;
					integ_pkg::TIMING_OFS: timing_next = link.dataByte;
					integ_pkg::GAIN_OFS: gain_next = link.dataByte;
					default: ;
				endcase
			end
		end
	end

	// Defaults loaded at reset before any host write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			control_reg <= integ_pkg::CONTROL_RST;
			timing_reg <= integ_pkg::TIMING_RST;
			gain_reg <= integ_pkg::GAIN_RST;
			addr_reg <= 5'h00;
			haveAddr_reg <= 1'b0;
		end else begin
			control_reg <= control_next;
			timing_reg <= timing_next;
			gain_reg <= gain_next;
			addr_reg <= addr_next;
			haveAddr_reg <= haveAddr_next;
		end
	end

	// Sync pin crosses in on two flops before edge detection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			syncOld_reg <= 1'b0;
		end else begin
			sync1_reg <= link.syncPin;
			sync2_reg <= sync1_reg;
			syncOld_reg <= sync2_reg;
		end
	end

	// ==========================================================
	// Integration controller
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b10
	} state_e;
	state_e state_reg, state_next;
	logic [26:0] timer_reg, timer_next;
	logic [3:0] count_reg, count_next;
	logic [26:0] target;
	logic enable;
	logic syncRise, syncFall;
	logic integ_next, integ_reg;
	logic done_next, done_reg;
	integ_pkg::mode_e mode;
	logic [1:0] integration_parameter;

	assign enable = control_reg[integ_pkg::ENABLE_BIT] & control_reg[integ_pkg::POWER_BIT];
	assign mode = integ_pkg::mode_e'(timing_reg[integ_pkg::MODE_LSB +: 2]);
	assign integration_parameter = timing_reg[1:0];
	assign syncRise = sync2_reg & ~syncOld_reg;
	assign syncFall = ~sync2_reg & syncOld_reg;

	// Nominal length from parameter field, 101 ms free-run, 100 ms one-shot
	always_comb begin
		unique case (integration_parameter)
			2'b00: target = 27'(CYC12);
			2'b01: target = (mode == integ_pkg::MODE_ONESHOT) ? 27'(CYC100) :
				27'(integ_pkg::C101);
			2'b10: target = 27'(CYC400);
			default: target = 27'(CYC400);
		endcase
	end

	// Mode dependent start and end of integration
	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		count_next = count_reg;
		integ_next = integ_reg;
		done_next = 1'b0;
		if (!enable) begin
			// Clearing enable rearms the sync modes and ends manual cycles
			state_next = ST_IDLE;
			timer_next = 27'h0;
			count_next = 4'h0;
			integ_next = 1'b0;
			done_next = integ_reg && (mode == integ_pkg::MODE_MANUAL);
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					unique case (mode)
						integ_pkg::MODE_FREE, integ_pkg::MODE_MANUAL: begin
							state_next = ST_RUN;
							integ_next = 1'b1;
						end
						integ_pkg::MODE_ONESHOT, integ_pkg::MODE_PULSE: begin
							if (syncRise) begin
								state_next = ST_RUN;
								integ_next = 1'b1;
								count_next = 4'h1;
							end
						end
					endcase
					timer_next = 27'h0;
				end
				ST_RUN: begin
					unique case (mode)
						integ_pkg::MODE_FREE: begin
							timer_next = timer_reg + 27'h1;
							if (timer_reg + 27'h1 >= target) begin
								timer_next = 27'h0; // Back to back cycles
								done_next = 1'b1;
							end
						end
						integ_pkg::MODE_MANUAL: ; // Ends only when enable drops
						integ_pkg::MODE_ONESHOT: begin
							timer_next = timer_reg + 27'h1;
							if (timer_reg + 27'h1 >= target) begin
								state_next = ST_DONE;
								integ_next = 1'b0;
								done_next = 1'b1;
							end
						end
						integ_pkg::MODE_PULSE: begin
							integ_next = sync2_reg; // Accumulate only while high
							if (syncRise)
								count_next = count_reg + 4'h1;
							if (timing_reg[integ_pkg::EDGE_BIT] && syncRise &&
								count_reg == 4'(integration_parameter) + 4'h1) begin // Rise of pulse N+1
								state_next = ST_DONE;
								integ_next = 1'b0;
								done_next = 1'b1;
							end else if (!timing_reg[integ_pkg::EDGE_BIT] && syncFall &&
								count_reg == 4'(integration_parameter) + 4'h1) begin
								state_next = ST_DONE;
								integ_next = 1'b0;
								done_next = 1'b1;
							end
						end
					endcase
				end
				ST_DONE: ; // Waits for enable toggle
				default: state_next = ST_IDLE;
			endcase
		end
	end

	// Controller state registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			timer_reg <= 27'h0;
			count_reg <= 4'h0;
			integ_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			count_reg <= count_next;
			integ_reg <= integ_next;
			done_reg <= done_next;
		end
	end

	assign integrating = integ_reg;
	assign cycleDone = done_reg;
	assign controlValue = control_reg;
	assign timingValue = timing_reg;
	assign gainValue = gain_reg;
	assign pulseCount = count_reg;
endmodule : integ_sensor
`default_nettype wire

// ==== include/integ_pkg.sv ====
// Package of register map, field layout and timing constants for integration control
// Operation
// - Registers take default values at reset
// - Free-run, one-shot, manual and pulse modes
// - Internal integration length from parameter field
// - Manual mode follows conversion-enable bit
// - Host follows ordered manual cycle steps
// - One-shot starts on sync rising edge
// - Host toggles enable before next sync cycle
// - One-shot lengths 12, 100, 400 ms
// - Pulse mode integrates from first rising edge
// - Rising select ends at pulse N+1 rise
// - Falling select ends at pulse N fall
// - Count sync edges, integrate while high
// - Sync pulses high at least 50 us
// - Timing 0x21 arms one-shot 100 ms
// - Timing 0x30 selects one-pulse accumulate
// - Timing 0x01 selects 101 ms free-run
// - Gain 0x20 sets 16x gain independently
// - Control 0x03 starts, 0x01 stops
// - Host releases sync before reading data
// - Command byte MSB marks register access
package integ_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [4:0] CONTROL_OFS = 5'h00;
	localparam logic [4:0] TIMING_OFS = 5'h01;
	localparam logic [4:0] GAIN_OFS = 5'h07;
	// Command byte fields
	localparam int CMD_SEL_BIT = 7;
	localparam int CMD_WORD_BIT = 5;
	localparam logic [7:0] CMD_SEL = 8'h80;
	localparam logic [7:0] CMD_WORD = 8'h20;
	// Field positions
	localparam int POWER_BIT = 0;
	localparam int ENABLE_BIT = 1;
	localparam int MODE_LSB = 4;
	localparam int EDGE_BIT = 3;
	localparam int GAIN_LSB = 4;
	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] TIMING_RST = 8'h00;
	localparam logic [7:0] GAIN_RST = 8'h00;
	// Register values used by software
	localparam logic [7:0] TIMING_MANUAL = 8'h10;
	localparam logic [7:0] TIMING_ONESHOT_100 = 8'h21;
	localparam logic [7:0] TIMING_PULSE_1 = 8'h30;
	localparam logic [7:0] TIMING_FREE_101 = 8'h01;
	localparam logic [7:0] GAIN_16X = 8'h20;
	localparam logic [7:0] CONTROL_RUN = 8'h03;
	localparam logic [7:0] CONTROL_STOP = 8'h01;
	// Integration modes
	typedef enum logic [1:0] {
		MODE_FREE = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_ONESHOT = 2'b10,
		MODE_PULSE = 2'b11
	} mode_e;
	// Integration times, microseconds, and cycle counts at 100 MHz
	localparam longint CLK_HZ = 100000000;
	localparam longint T12_US = 12000;
	localparam longint T100_US = 100000;
	localparam longint T101_US = 101000;
	localparam longint T400_US = 400000;
	localparam longint SYNC_MIN_US = 50;
	localparam longint C12 = T12_US * CLK_HZ / 1000000;
	localparam longint C100 = T100_US * CLK_HZ / 1000000;
	localparam longint C101 = T101_US * CLK_HZ / 1000000;
	localparam longint C400 = T400_US * CLK_HZ / 1000000;
	localparam longint SYNC_MIN_CYC = SYNC_MIN_US * CLK_HZ / 1000000;
endpackage : integ_pkg

// ==== include/integ_if.sv ====
// Interface joining the host end and the sensor integration end
`timescale 1ns/1ps
`default_nettype none
interface integ_if;
	logic cmdValid;
	logic [7:0] cmdByte;
	logic [7:0] dataByte;
	logic syncPin;
	modport sensor (input cmdValid, input cmdByte, input dataByte, input syncPin);
	modport host (output cmdValid, output cmdByte, output dataByte, output syncPin);
endinterface : integ_if
`default_nettype wire

// ==== design/integ_host.sv ====
// Host end: turns register write requests and sync requests into link traffic
`timescale 1ns/1ps
`default_nettype none
module integ_host (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wrReq,
	input wire logic [4:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic syncLevel,
	output logic wrBusy,
	integ_if.host link
);
	// ==========================================================
	// Two-beat write sequencer: command then data
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_CMD = 2'b01,
		H_DATA = 2'b10
	} hstate_e;
	hstate_e state_reg, state_next;
	logic [4:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic valid_reg, valid_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] out_reg, out_next;
	logic sync_reg;

	// Command byte carries select bit and register address
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		valid_next = 1'b0;
		cmd_next = cmd_reg;
		out_next = out_reg;
		unique case (state_reg)
			H_IDLE: if (wrReq) begin
				addr_next = wrAddr;
				data_next = wrData;
				state_next = H_CMD;
			end
			H_CMD: begin
				valid_next = 1'b1;
				cmd_next = integ_pkg::CMD_SEL | {3'h0, addr_reg};
				state_next = H_DATA;
			end
			H_DATA: begin
				valid_next = 1'b1;
				cmd_next = 8'h00;
				out_next = data_reg;
				state_next = H_IDLE;
			end
			default: state_next = H_IDLE;
		endcase
	end

	// Sequencer registers; user sequences steps and sync timing
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= H_IDLE;
			addr_reg <= 5'h00;
			data_reg <= 8'h00;
			valid_reg <= 1'b0;
			cmd_reg <= 8'h00;
			out_reg <= 8'h00;
			sync_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			valid_reg <= valid_next;
			cmd_reg <= cmd_next;
			out_reg <= out_next;
			sync_reg <= syncLevel;
		end
	end

	assign wrBusy = (state_reg != H_IDLE);
	assign link.cmdValid = valid_reg;
	assign link.cmdByte = cmd_reg;
	assign link.dataByte = out_reg;
	assign link.syncPin = sync_reg;
endmodule : integ_host
`default_nettype wire

// ==== tb/integ_checker_properties.sv ====
// Checker of link writes and integration timing
`timescale 1ns/1ps
`default_nettype none
module integ_checker #(
	parameter longint CYC12 = 100,
	parameter longint CYC100 = 200,
	parameter longint CYC400 = 400
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cmdValid,
	input wire logic [7:0] cmdByte,
	input wire logic [7:0] dataByte,
	input wire logic syncPin,
	input wire logic integrating,
	input wire logic cycleDone,
	input wire logic [7:0] controlValue,
	input wire logic [7:0] timingValue,
	input wire logic [7:0] gainValue,
	input wire logic [3:0] pulseCount
);
	// ==========
	// Helpers
	logic [4:0] addrReg, addrNext;
	logic [31:0] runReg, runNext, target;
	logic spentReg, spentNext;
	logic [1:0] mode;
	assign mode = timingValue[5:4];
	// Spent holds until enable drops, matching the re-arm handshake
	always_comb begin
		addrNext = (cmdValid && cmdByte[7]) ? cmdByte[4:0] : addrReg;
		runNext = integrating ? runReg + 32'h1 : 32'h0;
		spentNext = cycleDone ? 1'b1 : (controlValue[1] ? spentReg : 1'b0);
		target = (timingValue[1:0] == 2'h0) ? 32'(CYC12) :
			(timingValue[1:0] == 2'h1) ? 32'(CYC100) : 32'(CYC400);
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addrReg <= 5'h00;
			runReg <= 32'h0;
			spentReg <= 1'b0;
		end else begin
			addrReg <= addrNext;
			runReg <= runNext;
			spentReg <= spentNext;
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_reset_regs_clear: assert property ($fell(rst) |-> controlValue == 8'h00 &&
		timingValue == 8'h00 && gainValue == 8'h00) else $error("defaults wrong");
	a_timing_write: assert property (cmdValid && !cmdByte[7] && addrReg == 5'h01
		|=> timingValue == $past(dataByte)) else $error("timing write lost");
	a_gain_write: assert property (cmdValid && !cmdByte[7] && addrReg == 5'h07
		|=> gainValue == $past(dataByte) && $stable(timingValue)) else $error("gain write lost");
	a_manual_start: assert property (mode == 2'h1 && controlValue[0] &&
		$rose(controlValue[1]) |-> ##[0:3] integrating) else $error("manual no start");
	a_manual_stop: assert property (mode == 2'h1 && $fell(controlValue[1])
		|-> ##[0:3] cycleDone) else $error("manual no stop");
	a_sync_ignored: assert property (!mode[1] && $rose(syncPin)
		|=> $stable(pulseCount) [*4]) else $error("sync counted");
	a_oneshot_start: assert property (mode == 2'h2 && controlValue[1:0] == 2'h3 &&
		!spentReg && !integrating && $rose(syncPin) |-> ##[1:5] integrating)
		else $error("one-shot no start");
	a_oneshot_length: assert property (mode == 2'h2 && $fell(integrating)
		|-> runReg == target) else $error("one-shot length");
	a_oneshot_once: assert property (mode == 2'h2 && spentReg && $past(spentReg)
		|-> !integrating) else $error("one-shot rerun");
	a_pulse_gated: assert property (mode == 2'h3 && integrating |-> $past(syncPin, 3) ||
		$past(syncPin, 4) || $past(syncPin, 5)) else $error("integrating while sync low");
	a_pulse_end: assert property (mode == 2'h3 && cycleDone |-> pulseCount ==
		timingValue[1:0] + (timingValue[3] ? 4'h2 : 4'h1)) else $error("pulse end count");
endmodule : integ_checker
`default_nettype wire

// ==== tb/test_integration_sync_control.sv ====
// Bench joining host end and sensor end through the link
`timescale 1ns/1ps
`default_nettype none
module test_integration_sync_control;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wrReq = 1'b0;
	logic [4:0] wrAddr = 5'h00;
	logic [7:0] wrData = 8'h00;
	logic syncLevel = 1'b0;
	int doneCount = 0;
	logic wrBusy, integrating, cycleDone;
	logic [7:0] controlValue, timingValue, gainValue;
	logic [3:0] pulseCount;
	int nFail = 0;
	int totalChecks = 0;
	// Short counts keep one-shot runs brief; the checker's defaults are these same counts
	localparam longint SIM12 = 100;
	localparam longint SIM100 = 200;
	localparam longint SIM400 = 400;
	integ_if link();
	// ==========
	// Instances
	always #5 sys_clk = ~sys_clk;
	integ_host i_integ_host (.sys_clk(sys_clk), .rst(rst), .wrReq(wrReq), .wrAddr(wrAddr),
		.wrData(wrData), .syncLevel(syncLevel), .wrBusy(wrBusy), .link(link.host));
	// Sensor end runs with the short simulation counts
	integ_sensor #(.CYC12(SIM12), .CYC100(SIM100), .CYC400(SIM400)) i_integ_sensor (
		.sys_clk(sys_clk),
		.rst(rst), .link(link.sensor), .integrating(integrating), .cycleDone(cycleDone),
		.controlValue(controlValue), .timingValue(timingValue), .gainValue(gainValue),
		.pulseCount(pulseCount));
	integ_checker i_integ_checker (.sys_clk(sys_clk),
		.rst(rst), .cmdValid(link.cmdValid), .cmdByte(link.cmdByte), .dataByte(link.dataByte),
		.syncPin(link.syncPin), .integrating(integrating), .cycleDone(cycleDone),
		.controlValue(controlValue), .timingValue(timingValue), .gainValue(gainValue),
		.pulseCount(pulseCount));
	// Running count of done pulses; tasks compare against a snapshot, so one driver only
	always @(posedge sys_clk) if (cycleDone === 1'b1) doneCount <= doneCount + 1;
	// ==========
	// Tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		totalChecks++;
		if (g !== e) begin
			nFail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		wrReq = 1'b1;
		wrAddr = a;
		wrData = d;
		@(negedge sys_clk);
		wrReq = 1'b0;
		chk("write busy", 16'h1, 16'(wrBusy));
		repeat (7) @(negedge sys_clk);
	endtask : wr
	task automatic pulse(input longint hi);
		syncLevel = 1'b1;
		repeat (hi) @(negedge sys_clk);
		syncLevel = 1'b0;
		repeat (100) @(negedge sys_clk);
	endtask : pulse
	task automatic t_regs;
		chk("control", 8'h00, controlValue);
		chk("timing", 8'h00, timingValue);
		chk("gain", 8'h00, gainValue);
		wr(5'h07, 8'h20);
		wr(5'h01, 8'h01);
		wr(5'h05, 8'hff);
		chk("gain", 8'h20, gainValue);
		chk("timing", 8'h01, timingValue);
		chk("control", 8'h00, controlValue);
	endtask : t_regs
	task automatic t_free;
		int n;
		wr(5'h01, 8'h00);
		wr(5'h00, 8'h03);
		for (int i = 0; i < 200 && cycleDone !== 1'b1; i++) @(negedge sys_clk);
		n = 0;
		repeat (250) begin
			@(negedge sys_clk);
			n += int'(cycleDone);
		end
		chk("free periods", 2, n[15:0]);
	endtask : t_free
	task automatic t_manual;
		logic [3:0] pc;
		int base;
		wr(5'h00, 8'h01);
		wr(5'h01, 8'h10);
		wr(5'h00, 8'h03);
		chk("manual run", 1, integrating);
		pc = pulseCount;
		pulse(20);
		chk("sync count", pc, pulseCount);
		base = doneCount;
		wr(5'h00, 8'h01);
		chk("manual stop", 0, integrating);
		chk("manual done", 16'h1, 16'(doneCount - base));
	endtask : t_manual
	task automatic t_oneshot(input logic [1:0] p, input int cyc);
		int n;
		n = 0;
		wr(5'h00, 8'h01);
		wr(5'h01, {6'h08, p});
		wr(5'h00, 8'h03);
		syncLevel = 1'b1;
		for (int i = 0; i < 20 && integrating !== 1'b1; i++) @(negedge sys_clk);
		while (integrating === 1'b1 && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("one-shot length", cyc[15:0], n[15:0]);
		syncLevel = 1'b0;
		repeat (20) @(negedge sys_clk);
		syncLevel = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk("one-shot rerun", 0, integrating);
		syncLevel = 1'b0;
	endtask : t_oneshot
	task automatic t_pulse(input logic e, input logic [1:0] p);
		int base;
		wr(5'h00, 8'h01);
		wr(5'h01, {4'h3, e, 1'b0, p});
		wr(5'h00, 8'h03);
		base = doneCount;
		repeat (int'(p) + int'(e)) pulse(integ_pkg::SYNC_MIN_CYC + 10);
		chk("early end", 16'h0, 16'(doneCount - base));
		syncLevel = 1'b1;
		repeat (e ? 10 : integ_pkg::SYNC_MIN_CYC + 10) @(negedge sys_clk);
		if (!e) begin
			chk("pulse gate", 1, integrating);
			syncLevel = 1'b0;
			repeat (10) @(negedge sys_clk);
		end
		chk("pulse end", 16'h1, 16'(doneCount - base));
		chk("pulse count", 16'(p) + (e ? 16'h2 : 16'h1), 16'(pulseCount));
		syncLevel = 1'b0;
		repeat (20) @(negedge sys_clk);
	endtask : t_pulse
	task automatic wrapUp;
		if (nFail == 0 && totalChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrapUp
	// ==========
	// Sequence and watchdog
	initial begin
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		t_regs;
		t_free;
		t_manual;
		t_oneshot(2'h0, 100);
		t_oneshot(2'h1, 200);
		t_oneshot(2'h2, 400);
		t_oneshot(2'h3, 400);
		t_pulse(1'b1, 2'h0);
		t_pulse(1'b0, 2'h0);
		t_pulse(1'b1, 2'h1);
		t_pulse(1'b0, 2'h2);
		wrapUp;
	end
	// Run needs about 38k cycles, so 100k cycles means a hang
	initial begin
		#1000000;
		nFail++;
		wrapUp;
	end
endmodule : test_integration_sync_control
`default_nettype wire
